// File: logic/gate_drv_pkg.sv
/*
 * constants, mode encoding and the frame check function of the gate driver
 * logic interface. assumes a 200 MHz system clock.
 */
package gate_drv_pkg;
    localparam int CLK_HZ = 200_000_000;
    // serial frame: 16 payload bits then 8 check bits, msb first
    localparam int FRAME_BITS = 24;
    localparam int PAYLOAD_BITS = 16;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;
    // payload layout of a write frame
    localparam int CFG_WR_BIT = 15;
    localparam int CFG_MUX_BIT = 0;
    localparam int CFG_CONF_BIT = 1;
    localparam int CFG_CLR_BIT = 2;
    localparam logic [1:0] CFG_RST = 2'h0;
    // pin order of the synchroniser vector
    localparam int PIN_SEL = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_CMD = 3;
    localparam int PIN_ALT = 4;
    localparam int PIN_HVFS = 5;
    localparam int PIN_LVFS = 6;
    localparam int PIN_FSLVL = 7;
    localparam int PIN_HB = 8;
    localparam int PIN_N = 9;
    localparam logic [8:0] PIN_RST = 9'h041;
    // timing
    localparam int DEADTIME_NS = 500;
    localparam int DEAD_CYC = (DEADTIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WDOG_US = 20;
    localparam int WDOG_CYC = WDOG_US * (CLK_HZ / 1_000_000);
    localparam int RD_A_HZ = 3900;
    localparam int RD_B_HZ = 5600;
    localparam int MAX_SW_HZ = 100_000;

    typedef enum logic [2:0] {
        MODE_RESET = 3'h0,
        MODE_RUN = 3'h1,
        MODE_CONFIG = 3'h3,
        MODE_LV_FS = 3'h2,
        MODE_HV_FS = 3'h6,
        MODE_FAULT = 3'h7
    } mode_t;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = PAYLOAD_BITS - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction
endpackage

// File: logic/serial_link_if.sv
/*
 * carrier between the driver core and its serial link engine.
 * assumes pin levels are already synchronised to sys_clk_in.
 */
`timescale 1ns/1ps
interface serial_link_if;
    logic sel_low;
    logic sclk;
    logic mosi;
    logic [15:0] status;
    logic miso;
    logic frame_pulse;
    logic frame_good;
    logic [15:0] rx_payload;
    modport core (output sel_low, sclk, mosi, status,
                  input miso, frame_pulse, frame_good, rx_payload);
    modport engine (input sel_low, sclk, mosi, status,
                    output miso, frame_pulse, frame_good, rx_payload);
endinterface

// File: logic/serial_engine.sv
/*
 * serial link engine: shifts frames in and out on filtered link clock edges.
 * assumes synchronised, glitch-filtered pin levels on the same clock.
 */
`timescale 1ns/1ps
module serial_engine
    import gate_drv_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    serial_link_if.engine lnk
);
    logic sclk_d_r;
    logic sel_d_r;
    logic [23:0] rx_r;
    logic [23:0] tx_r;
    logic [4:0] cnt_r;
    logic pulse_r;
    logic good_r;
    logic [15:0] payload_r;
    logic active;
    logic rise;
    logic fall;

    assign active = ~lnk.sel_low;
    assign rise = active & lnk.sclk & ~sclk_d_r;
    assign fall = active & ~lnk.sclk & sclk_d_r;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sclk_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            sclk_d_r <= lnk.sclk;
            sel_d_r <= lnk.sel_low;
        end
    end

    // receive on rising edges, msb first; a low select frames the word
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || lnk.sel_low) begin
            rx_r <= 24'h000000;
            cnt_r <= 5'h00;
        end else if (rise) begin
            rx_r <= {rx_r[22:0], lnk.mosi};
            if (cnt_r != 5'h1f) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // transmit: first bit stands before the first rising edge
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tx_r <= 24'h000000;
        end else if (sel_d_r && !lnk.sel_low) begin
            tx_r <= {lnk.status, crc8(lnk.status)};
        end else if (fall) begin
            tx_r <= {tx_r[22:0], 1'b0};
        end
    end
    assign lnk.miso = tx_r[23];

    // frame closes on select rising; wrong length counts as a bad frame
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pulse_r <= 1'b0;
            good_r <= 1'b0;
            payload_r <= 16'h0000;
        end else begin
            pulse_r <= !sel_d_r && lnk.sel_low;
            good_r <= (cnt_r == 5'(FRAME_BITS)) && (crc8(rx_r[23:8]) == rx_r[7:0]);
            if (!sel_d_r && lnk.sel_low) begin
                payload_r <= rx_r[23:8];
            end
        end
    end
    assign lnk.frame_pulse = pulse_r;
    assign lnk.frame_good = good_r;
    assign lnk.rx_payload = payload_r;

    property p_idle_no_count;
        @(posedge sys_clk_in) disable iff (rst_in)
        lnk.sel_low |=> (cnt_r == 5'h00);
    endproperty
    a_idle_no_count: assert property (p_idle_no_count)
        else $error("bit count moved while select high");

    property p_sample_rise;
        @(posedge sys_clk_in) disable iff (rst_in)
        rise && !lnk.sel_low |=> (rx_r[0] == $past(lnk.mosi)) && (cnt_r != 5'h00);
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("data not sampled on rising edge");

    property p_change_on_fall;
        @(posedge sys_clk_in) disable iff (rst_in)
        $changed(tx_r) |-> $past(fall) || ($past(sel_d_r) && !$past(lnk.sel_low));
    endproperty
    a_change_on_fall: assert property (p_change_on_fall)
        else $error("output data changed off a falling edge");
endmodule

// File: logic/gate_driver_lv.sv
/*
 * low-voltage logic interface of an isolated single-channel gate driver.
 * assumes all pins are asynchronous to sys_clk_in; converter codes and the
 * barrier heartbeat come from the barrier receiver (heartbeat is synchronised).
 */
`timescale 1ns/1ps
module gate_driver_lv
    import gate_drv_pkg::*;
#(
    parameter logic HV_GATE_ON = 1'b1,  // product variant: 1 gate on, 0 floating
    parameter int RD_A_CYC = CLK_HZ / RD_A_HZ,
    parameter int RD_B_CYC = CLK_HZ / RD_B_HZ
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // serial link
    input wire logic serial_select_low_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    // gate commands and fail-safe pins
    input wire logic gate_cmd_in,
    input wire logic complementary_gate_cmd_in,
    input wire logic hv_failsafe_in,
    input wire logic lv_failsafe_enable_low_in,
    input wire logic failsafe_gate_level_in,
    // barrier side
    input wire logic barrier_heartbeat_in,
    input wire logic [7:0] adc_code_in,
    input wire logic [7:0] adc_alt_code_in,
    // outputs
    output logic gate_on_out,
    output logic gate_drive_en_out,
    output logic fault_flag_low_out,
    output logic duty_encoded_readout_out
);
    function automatic logic [15:0] duty_thr(input logic [15:0] per, input logic [7:0] code);
        logic [23:0] p;
        p = per * code;
        return p[23:8];
    endfunction

    serial_link_if lnk ();
    logic [PIN_N-1:0] s1_r, s2_r, s3_r, filt_r;
    logic [PIN_N-1:0] pins;
    mode_t mode_r, mode_nxt;
    logic [1:0] cfg_r;
    logic clear_req;
    logic crc_err_r;
    logic wdog_fault_r;
    logic [15:0] wd_cnt_r;
    logic hb_d_r;
    logic [7:0] dead_cnt_r;
    logic pwm_ok;
    logic gate_on_r, gate_en_r;
    logic gate_on_nxt, gate_en_nxt;
    logic [15:0] rd_cnt_r;
    logic rd_phase_r;
    logic [15:0] rd_per;
    logic [7:0] rd_code;

    // three-stage synchroniser; a level counts once stages two and three agree
    assign pins = {barrier_heartbeat_in, failsafe_gate_level_in, lv_failsafe_enable_low_in,
                   hv_failsafe_in, complementary_gate_cmd_in, gate_cmd_in,
                   serial_data_in, serial_clk_in, serial_select_low_in};
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s1_r <= PIN_RST;
            s2_r <= PIN_RST;
            s3_r <= PIN_RST;
            filt_r <= PIN_RST;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
        end
    end

    assign lnk.sel_low = filt_r[PIN_SEL];
    assign lnk.sclk = filt_r[PIN_SCLK];
    assign lnk.mosi = filt_r[PIN_MOSI];
    assign lnk.status = {6'h00, cfg_r, mode_r, gate_on_r, gate_en_r, wdog_fault_r,
                         crc_err_r, 1'b0};

    serial_engine u_engine (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .lnk(lnk)
    );

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            serial_data_out <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else begin
            serial_data_out <= lnk.miso;
            serial_data_oe_out <= ~filt_r[PIN_SEL];
        end
    end

    // configuration written by checked frames only
    assign clear_req = lnk.frame_pulse && lnk.frame_good && lnk.rx_payload[CFG_WR_BIT]
                       && lnk.rx_payload[CFG_CLR_BIT];
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_r <= CFG_RST;
        end else if (lnk.frame_pulse && lnk.frame_good && lnk.rx_payload[CFG_WR_BIT]) begin
            cfg_r <= {lnk.rx_payload[CFG_CONF_BIT], lnk.rx_payload[CFG_MUX_BIT]};
        end
    end

    // a bad frame is latched; a clear in the same cycle loses
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            crc_err_r <= 1'b0;
        end else if (lnk.frame_pulse && !lnk.frame_good) begin
            crc_err_r <= 1'b1;
        end else if (clear_req) begin
            crc_err_r <= 1'b0;
        end
    end

    // barrier watchdog: any heartbeat transition restarts it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            hb_d_r <= 1'b0;
            wd_cnt_r <= 16'h0000;
            wdog_fault_r <= 1'b0;
        end else begin
            hb_d_r <= filt_r[PIN_HB];
            if (hb_d_r != filt_r[PIN_HB]) begin
                wd_cnt_r <= 16'h0000;
            end else if (wd_cnt_r != 16'(WDOG_CYC)) begin
                wd_cnt_r <= wd_cnt_r + 16'h0001;
            end
            if (wd_cnt_r == 16'(WDOG_CYC)) begin
                wdog_fault_r <= 1'b1;
            end else if (clear_req) begin
                wdog_fault_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            fault_flag_low_out <= 1'b1;
        end else begin
            fault_flag_low_out <= ~(crc_err_r | wdog_fault_r);
        end
    end

    // deadtime: complementary command must have been low long enough
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || filt_r[PIN_ALT]) begin
            dead_cnt_r <= 8'h00;
        end else if (dead_cnt_r != 8'(DEAD_CYC)) begin
            dead_cnt_r <= dead_cnt_r + 8'h01;
        end
    end
    // no rate limiter: the host keeps below the switching limit
    assign pwm_ok = filt_r[PIN_CMD] && !filt_r[PIN_ALT]
                    && (dead_cnt_r == 8'(DEAD_CYC));

    always_comb begin
        if (filt_r[PIN_HVFS]) begin
            mode_nxt = MODE_HV_FS;
        end else if (!filt_r[PIN_LVFS]) begin
            mode_nxt = MODE_LV_FS;
        end else if (wdog_fault_r) begin
            mode_nxt = MODE_FAULT;
        end else if (cfg_r[1]) begin
            mode_nxt = MODE_CONFIG;
        end else begin
            mode_nxt = MODE_RUN;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_r <= MODE_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_comb begin
        gate_on_nxt = 1'b0;
        gate_en_nxt = 1'b1;
        unique case (mode_r)
            MODE_RUN: gate_on_nxt = pwm_ok;
            MODE_LV_FS: gate_on_nxt = filt_r[PIN_FSLVL];
            MODE_HV_FS: begin
                gate_on_nxt = HV_GATE_ON;
                gate_en_nxt = HV_GATE_ON;
            end
            MODE_RESET, MODE_CONFIG, MODE_FAULT: gate_on_nxt = 1'b0;
            default: gate_on_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            gate_on_r <= 1'b0;
            gate_en_r <= 1'b1;
        end else begin
            gate_on_r <= gate_on_nxt;
            gate_en_r <= gate_en_nxt;
        end
    end
    assign gate_on_out = gate_on_r;
    assign gate_drive_en_out = gate_en_r;

    // duty readout; mux mode alternates the two carriers each period
    assign rd_per = rd_phase_r ? 16'(RD_B_CYC) : 16'(RD_A_CYC);
    assign rd_code = rd_phase_r ? adc_alt_code_in : adc_code_in;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_cnt_r <= 16'h0000;
            rd_phase_r <= 1'b0;
            duty_encoded_readout_out <= 1'b0;
        end else begin
            if (rd_cnt_r >= rd_per - 16'h0001) begin
                rd_cnt_r <= 16'h0000;
                rd_phase_r <= cfg_r[0] & ~rd_phase_r;
            end else begin
                rd_cnt_r <= rd_cnt_r + 16'h0001;
            end
            duty_encoded_readout_out <= rd_cnt_r < duty_thr(rd_per, rd_code);
        end
    end

    property p_fault_low;
        @(posedge sys_clk_in) disable iff (rst_in)
        (crc_err_r || wdog_fault_r) |=> !fault_flag_low_out;
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("fault not shown low");

    property p_gate_follows;
        @(posedge sys_clk_in) disable iff (rst_in)
        (mode_r == MODE_RUN) |=> (gate_on_r == $past(pwm_ok));
    endproperty
    a_gate_follows: assert property (p_gate_follows)
        else $error("gate does not follow command");

    property p_cmd_ignored;
        @(posedge sys_clk_in) disable iff (rst_in)
        (mode_r == MODE_CONFIG || mode_r == MODE_FAULT) |=> !gate_on_r;
    endproperty
    a_cmd_ignored: assert property (p_cmd_ignored)
        else $error("gate on in a blocking mode");

    property p_both_high_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        (mode_r == MODE_RUN && filt_r[PIN_ALT]) |=> !gate_on_r;
    endproperty
    a_both_high_off: assert property (p_both_high_off)
        else $error("gate on with complementary high");

    property p_hv_override;
        @(posedge sys_clk_in) disable iff (rst_in)
        filt_r[PIN_HVFS] [*2] |=> (gate_on_r == HV_GATE_ON) && (gate_en_r == HV_GATE_ON);
    endproperty
    a_hv_override: assert property (p_hv_override)
        else $error("high-side fail-safe not applied");

    property p_lv_failsafe;
        @(posedge sys_clk_in) disable iff (rst_in)
        (mode_r == MODE_LV_FS) |=> (gate_on_r == $past(filt_r[PIN_FSLVL]));
    endproperty
    a_lv_failsafe: assert property (p_lv_failsafe)
        else $error("fail-safe level not driven");

    property p_wdog_trip;
        @(posedge sys_clk_in) disable iff (rst_in)
        (wd_cnt_r == 16'(WDOG_CYC)) |=> wdog_fault_r ##1 (mode_r != MODE_RUN);
    endproperty
    a_wdog_trip: assert property (p_wdog_trip)
        else $error("watchdog expiry not a fault");

    property p_rd_period;
        @(posedge sys_clk_in) disable iff (rst_in)
        rd_cnt_r < rd_per;
    endproperty
    a_rd_period: assert property (p_rd_period)
        else $error("readout counter beyond period");
endmodule

// File: sim/host_link_model.sv
/*
 * host side of the serial link: frames of 24 bits, mode 0, msb first.
 * assumes the bench calls xfer and stray from one process at a time.
 */
`timescale 1ns/1ps
module host_link_model (
    // clock
    input wire logic sys_clk_in,
    // link pins
    output logic select_low_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire logic miso_in
);
    initial begin
        select_low_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end

    function automatic logic [7:0] crc_of(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // half period of 8 cycles gives the 80 ns link clock
    task automatic half();
        repeat (8) @(posedge sys_clk_in);
    endtask

    // clock edges with select high, which the device must not count
    task automatic stray();
        for (int i = 0; i < 3; i++) begin
            half();
            sclk_out <= 1'b1;
            half();
            sclk_out <= 1'b0;
        end
    endtask

    task automatic xfer(input logic [15:0] pay, input logic bad, output logic [23:0] rx);
        logic [23:0] w;
        w = {pay, crc_of(pay) ^ {7'h00, bad}};
        @(posedge sys_clk_in);
        select_low_out <= 1'b0;
        half();
        for (int i = 23; i >= 0; i--) begin
            mosi_out <= w[i];
            half();
            sclk_out <= 1'b1;
            rx[i] = miso_in;
            half();
            sclk_out <= 1'b0;
        end
        half();
        select_low_out <= 1'b1;
        mosi_out <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
    endtask
endmodule

// File: sim/gate_driver_lv_logic_interface_tb.sv
/*
 * self-checking bench of the gate driver logic interface.
 * assumes shortened readout periods of 64 and 48 cycles.
 */
`timescale 1ns/1ps
module gate_driver_lv_logic_interface_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sel_low, sclk, mosi, miso, miso_oe;
    logic cmd = 1'b0;
    logic alt = 1'b0;
    logic hv = 1'b0;
    logic lv_en_low = 1'b1;
    logic lv_lvl = 1'b0;
    logic hb = 1'b0;
    logic hb_run = 1'b1;
    logic [7:0] code_a = 8'h80;
    logic [7:0] code_b = 8'h40;
    logic gate_on, gate_en, fault_low, readout;
    int bad_count = 0;
    int tests_run = 0;

    always #2.5 sys_clk = ~sys_clk;
    // heartbeat stands still when stopped, as a dead barrier would
    always begin
        repeat (100) @(posedge sys_clk);
        if (hb_run) hb <= ~hb;
    end

    host_link_model u_host_link_model (
        .sys_clk_in(sys_clk), .select_low_out(sel_low), .sclk_out(sclk),
        .mosi_out(mosi), .miso_in(miso)
    );

    gate_driver_lv #(.HV_GATE_ON(1'b1), .RD_A_CYC(64), .RD_B_CYC(48)) u_gate_driver_lv (
        .sys_clk_in(sys_clk), .rst_in(rst),
        .serial_select_low_in(sel_low), .serial_clk_in(sclk), .serial_data_in(mosi),
        .serial_data_out(miso), .serial_data_oe_out(miso_oe),
        .gate_cmd_in(cmd), .complementary_gate_cmd_in(alt), .hv_failsafe_in(hv),
        .lv_failsafe_enable_low_in(lv_en_low), .failsafe_gate_level_in(lv_lvl),
        .barrier_heartbeat_in(hb), .adc_code_in(code_a), .adc_alt_code_in(code_b),
        .gate_on_out(gate_on), .gate_drive_en_out(gate_en),
        .fault_flag_low_out(fault_low), .duty_encoded_readout_out(readout)
    );

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // command edges kept 1000 cycles apart: 100 kHz at most
    task automatic pwm(input logic v);
        @(posedge sys_clk);
        cmd <= v;
        wait_cyc(1000);
    endtask

    task automatic frame(input logic [15:0] pay, input logic bad, input logic [15:0] exp);
        logic [23:0] rx;
        u_host_link_model.xfer(pay, bad, rx);
        check(rx[23:8], exp, "status word");
        check(rx[7:0], u_host_link_model.crc_of(exp), "status check byte");
    endtask

    task automatic t_reset_values();
        check({fault_low, gate_on, gate_en, miso_oe}, 4'b1010, "idle outputs");
    endtask

    task automatic t_link();
        u_host_link_model.stray();
        // look at the data enable while the frame is still open
        fork
            frame(16'h0000, 1'b0, 16'h0028);
            begin
                wait_cyc(100);
                check(miso_oe, 1'b1, "data driven inside frame");
            end
        join
        check(miso_oe, 1'b0, "data released");
    endtask

    task automatic t_config();
        frame(16'h8002, 1'b0, 16'h0028);
        frame(16'h0000, 1'b0, 16'h0268);
        pwm(1'b1);
        check(gate_on, 1'b0, "command blocked in config");
        frame(16'h8004, 1'b0, 16'h0268);
        wait_cyc(200);
        check(gate_on, 1'b1, "gate on");
        pwm(1'b0);
        check(gate_on, 1'b0, "gate off");
    endtask

    task automatic t_deadtime();
        @(posedge sys_clk);
        alt <= 1'b1;
        pwm(1'b1);
        check(gate_on, 1'b0, "both commands high");
        @(posedge sys_clk);
        alt <= 1'b0;
        wait_cyc(90);
        check(gate_on, 1'b0, "inside deadtime");
        wait_cyc(30);
        check(gate_on, 1'b1, "after deadtime");
        pwm(1'b0);
    endtask

    task automatic t_bad_crc();
        frame(16'h8002, 1'b1, 16'h0028);
        wait_cyc(20);
        check(fault_low, 1'b0, "fault on bad check byte");
        frame(16'h0000, 1'b0, 16'h002a);
        frame(16'h8004, 1'b0, 16'h002a);
        wait_cyc(20);
        check(fault_low, 1'b1, "fault cleared");
    endtask

    task automatic t_failsafe();
        @(posedge sys_clk);
        lv_en_low <= 1'b0;
        lv_lvl <= 1'b1;
        wait_cyc(200);
        check(gate_on, 1'b1, "fail-safe level high");
        @(posedge sys_clk);
        lv_lvl <= 1'b0;
        pwm(1'b1);
        check(gate_on, 1'b0, "command ignored in fail-safe");
        @(posedge sys_clk);
        hv <= 1'b1;
        lv_lvl <= 1'b1;
        pwm(1'b0);
        check({gate_on, gate_en}, 2'b11, "high-side fail-safe");
        @(posedge sys_clk);
        lv_lvl <= 1'b0;
        wait_cyc(200);
        check(gate_on, 1'b1, "high-side overrides level");
        @(posedge sys_clk);
        hv <= 1'b0;
        lv_en_low <= 1'b1;
        wait_cyc(200);
        check(gate_on, 1'b0, "back to command");
    endtask

    task automatic count_high(input int n, input int exp);
        int hi;
        hi = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            #1;
            if (readout === 1'b1) hi++;
        end
        check(hi, exp, "readout high time");
    endtask

    task automatic t_readout();
        wait_cyc(200);
        count_high(64, 32);
        frame(16'h8001, 1'b0, 16'h0028);
        wait_cyc(200);
        count_high(112, 44);
        frame(16'h8004, 1'b0, 16'h0128);
    endtask

    task automatic t_watchdog();
        hb_run = 1'b0;
        wait_cyc(4300);
        check(fault_low, 1'b0, "barrier loss fault");
        pwm(1'b1);
        check(gate_on, 1'b0, "gate held off on barrier loss");
        pwm(1'b0);
    endtask

    initial begin
        wait_cyc(3);
        rst <= 1'b0;
        wait_cyc(10);
        t_reset_values();
        t_link();
        t_config();
        t_deadtime();
        t_bad_crc();
        t_failsafe();
        t_readout();
        t_watchdog();
        results();
    end

    // tests need about 18k cycles; give up after 50k
    initial begin
        #250000;
        bad_count++;
        results();
    end
endmodule
